// ==== reset_state_manager.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Command bit 0 resets the processor
// - Command bit 2 resets all peripherals
// - Command bit 3 pulses external line low
// - Software reset lasts three slow cycles
// - Assert on write, release on slow clock
// - Own line pulse never causes user reset
// - Cause updated only for processor command
// - Cause in status 10:8, read keeps it
// - Busy flag blocks further command writes
// - Watchdog reset lasts three slow cycles
// - Full watchdog reset also pulses line
// - Processor-only watchdog resets processor only
// - Disabled watchdog reset does nothing here
// - Priority: general, backup, watchdog, software, user
// - Watchdog preempts software; pin ignored then
// - Watchdog state blocks software and user
// - Status bit 16 shows pin level
// - Pin fall flag, cleared by status read
// - Interrupt from fall flag when enabled and user reset off
// - Mode bit 0 enables user reset
// - Line pulse lasts 2^(len+1) slow cycles
// - Key 0xA5 required, else write dropped
// - User reset leaves after pin high, startup
module reset_state_manager
    import reset_state_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Asynchronous inputs
    input  wire logic        slow_clock,
    input  wire logic        line_pin_in,
    input  wire logic        backup_req,
    // Watchdog side, same clock
    input  wire logic        wd_fault,
    input  wire logic        wd_cpu_only,
    input  wire logic        wd_reset_enable,
    // Reset outputs
    output logic             cpu_reset_n,
    output logic             periph_reset_n,
    output logic             line_pin_out,
    output logic             line_pin_oe,
    output logic             reset_irq
);
    import reset_state_pkg::*;

    // Whole block state
    typedef struct packed {
        logic                  slow_s1;
        logic                  slow_s2;
        logic                  slow_d;
        logic                  pin_s1;
        logic                  pin_s2;
        logic                  pin_d;
        logic                  bk_s1;
        logic                  bk_s2;
        rst_state_t            state;
        logic [1:0]            cnt;
        logic                  cpu_n;
        logic                  per_n;
        logic [LINE_CNT_W-1:0] line_cnt;
        logic                  line_oe;
        logic                  own_drive;
        logic                  busy;
        logic                  sw_cpu;
        logic [2:0]            cause;
        logic                  fall_seen;
        logic                  line_en;
        logic                  irq_en;
        logic [3:0]            line_len;
        logic                  irq;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  slverr;
    } state_t;

    state_t st_reg;   // Registered state
    state_t st_next;  // Next state

    // Decoded bus and timing events
    logic        slow_tick;  // Rising edge of synchronised slow clock
    logic        pin_fall;   // Synchronised pin high-to-low
    logic        acc_done;   // Access phase completing
    logic        wr_cmd;     // Keyed write to command
    logic        wr_mode;    // Keyed write to mode
    logic        rd_status;  // Status read completing
    logic        key_ok;     // Key field matches
    logic        sw_req;     // Accepted software command
    logic        wd_req;     // Watchdog fault taking effect
    logic        map_hit;    // Address is one of ours
    logic [31:0] status_val; // Status word
    logic [LINE_CNT_W-1:0] line_load; // Line pulse length in slow ticks

    assign slow_tick = st_reg.slow_s2 & ~st_reg.slow_d;
    assign pin_fall  = st_reg.pin_d & ~st_reg.pin_s2;
    assign acc_done  = psel & penable & st_reg.ready;
    assign key_ok    = (pwdata[31:KEY_LSB] == WRITE_KEY);
    assign wr_cmd    = acc_done & pwrite & key_ok & (paddr == OFS_RESET_COMMAND);
    assign wr_mode   = acc_done & pwrite & key_ok & (paddr == OFS_RESET_MODE);
    assign rd_status = acc_done & ~pwrite & (paddr == OFS_RESET_STATUS);
    assign map_hit   = (paddr == OFS_RESET_COMMAND) | (paddr == OFS_RESET_STATUS)
                     | (paddr == OFS_RESET_MODE);
    // One spare bit in the sum so the longest length cannot wrap to one tick
    assign line_load = LINE_CNT_W'(1) << ({1'b0, st_reg.line_len} + 5'h01);

    // Commands count only when idle and not busy; watchdog and user states block them
    assign sw_req = wr_cmd & ~st_reg.busy & (st_reg.state == ST_IDLE)
                  & (pwdata[CMD_CPU_BIT] | pwdata[CMD_PERIPH_BIT] | pwdata[CMD_LINE_BIT]);
    // Watchdog ignored when disabled, already active, or outside idle and software states
    assign wd_req = wd_fault & wd_reset_enable
                  & ((st_reg.state == ST_IDLE) | (st_reg.state == ST_SOFT));

    // Status word, reserved bits zero
    always_comb begin
        status_val = 32'h0000_0000;
        status_val[STS_FALL_BIT] = st_reg.fall_seen;
        status_val[STS_CAUSE_LSB +: 3] = st_reg.cause;
        status_val[STS_LEVEL_BIT] = st_reg.pin_s2;
        status_val[STS_BUSY_BIT] = st_reg.busy;
    end

    // Next-state logic for the whole block
    always_comb begin
        st_next = st_reg;
        // Two-stage synchronisers; first stage only feeds the second
        st_next.slow_s1 = slow_clock;
        st_next.slow_s2 = st_reg.slow_s1;
        st_next.slow_d  = st_reg.slow_s2;
        st_next.pin_s1  = line_pin_in;
        st_next.pin_s2  = st_reg.pin_s1;
        st_next.pin_d   = st_reg.pin_s2;
        st_next.bk_s1   = backup_req;
        st_next.bk_s2   = st_reg.bk_s1;

        // APB: no wait state; read data is registered in the setup cycle
        st_next.ready  = psel & ~penable;
        st_next.slverr = psel & ~penable & ~map_hit;
        st_next.rdata  = 32'h0000_0000;
        if (psel & ~penable & ~pwrite) begin
            if (paddr == OFS_RESET_STATUS) begin
                st_next.rdata = status_val;
            end else if (paddr == OFS_RESET_MODE) begin
                // Key reads back as zero
                st_next.rdata[MODE_EN_BIT]       = st_reg.line_en;
                st_next.rdata[MODE_IRQ_BIT]      = st_reg.irq_en;
                st_next.rdata[MODE_LEN_LSB +: 4] = st_reg.line_len;
            end
        end

        // Mode write, dropped unless keyed
        if (wr_mode) begin
            st_next.line_en  = pwdata[MODE_EN_BIT];
            st_next.irq_en   = pwdata[MODE_IRQ_BIT];
            st_next.line_len = pwdata[MODE_LEN_LSB +: 4];
        end

        // Line pulse counter runs on slow ticks
        if (slow_tick && st_reg.line_cnt != '0) begin
            st_next.line_cnt = st_reg.line_cnt - 1'b1;
        end
        // Own drive mark lasts until the pin is seen high again
        if (st_reg.line_cnt == '0 && st_reg.pin_s2) begin
            st_next.own_drive = 1'b0;
        end

        // Fall flag; a new fall wins over the read clear, and a fall seen
        // after the setup edge was not returned, so that read keeps it
        if (rd_status && st_reg.rdata[STS_FALL_BIT]) begin
            st_next.fall_seen = 1'b0;
        end
        if (pin_fall) begin
            st_next.fall_seen = 1'b1;
        end

        if (slow_tick && st_reg.cnt != 2'h0) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end

        case (st_reg.state)
            ST_IDLE: begin
                st_next.cpu_n = 1'b1;
                st_next.per_n = 1'b1;
                if (st_reg.bk_s2) begin
                    st_next.state = ST_BACKUP;
                    st_next.cpu_n = 1'b0;
                    st_next.per_n = 1'b0;
                end else if (wd_req) begin
                    st_next.state = ST_WDOG;
                end else if (sw_req) begin
                    // Resets assert on the write itself, not on a slow edge
                    st_next.state  = ST_SOFT;
                    st_next.cnt    = STATE_SLOW_CYCLES;
                    st_next.busy   = 1'b1;
                    st_next.sw_cpu = pwdata[CMD_CPU_BIT];
                    st_next.cpu_n  = ~pwdata[CMD_CPU_BIT];
                    st_next.per_n  = ~pwdata[CMD_PERIPH_BIT];
                    if (pwdata[CMD_LINE_BIT]) begin
                        st_next.line_cnt  = line_load;
                        st_next.own_drive = 1'b1;
                    end
                end else if (slow_tick && st_reg.line_en && !st_reg.pin_s2
                             && !st_reg.own_drive) begin
                    st_next.state = ST_USER;
                    st_next.cpu_n = 1'b0;
                    st_next.per_n = 1'b0;
                end
            end
            ST_SOFT: begin
                // Pin has no effect here; only backup or watchdog cuts in
                if (st_reg.bk_s2) begin
                    st_next.state = ST_BACKUP;
                    st_next.busy  = 1'b0;
                    st_next.cpu_n = 1'b0;
                    st_next.per_n = 1'b0;
                end else if (wd_req) begin
                    st_next.state = ST_WDOG;
                    st_next.busy  = 1'b0;
                end else if (slow_tick && st_reg.cnt == 2'h1) begin
                    // Release on the slow edge that ends the state
                    st_next.state = ST_IDLE;
                    st_next.busy  = 1'b0;
                    st_next.cpu_n = 1'b1;
                    st_next.per_n = 1'b1;
                    if (st_reg.sw_cpu) begin
                        st_next.cause = CAUSE_SOFTWARE;
                    end
                end
            end
            ST_WDOG: begin
                // Entry work is done on the way in, below the case
                if (st_reg.bk_s2) begin
                    st_next.state = ST_BACKUP;
                    st_next.per_n = 1'b0;
                end else if (slow_tick && st_reg.cnt == 2'h1) begin
                    st_next.state = ST_IDLE;
                    st_next.cpu_n = 1'b1;
                    st_next.per_n = 1'b1;
                    st_next.cause = CAUSE_WATCHDOG;
                end
            end
            ST_USER: begin
                // Held while the pin stays low, whoever drives it
                if (st_reg.bk_s2) begin
                    st_next.state = ST_BACKUP;
                end else if (st_reg.pin_s2) begin
                    st_next.state = ST_STARTUP;
                    st_next.cnt   = STARTUP_SLOW_CYCLES;
                end
            end
            ST_STARTUP: begin
                if (st_reg.bk_s2) begin
                    st_next.state = ST_BACKUP;
                end else if (!st_reg.pin_s2) begin
                    st_next.state = ST_USER;
                end else if (slow_tick && st_reg.cnt == 2'h1) begin
                    st_next.state = ST_IDLE;
                    st_next.cpu_n = 1'b1;
                    st_next.per_n = 1'b1;
                    st_next.cause = CAUSE_USER;
                end
            end
            ST_BACKUP: begin
                if (!st_reg.bk_s2) begin
                    st_next.state = ST_IDLE;
                    st_next.cpu_n = 1'b1;
                    st_next.per_n = 1'b1;
                    st_next.cause = CAUSE_BACKUP;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase

        // Watchdog entry from idle or software state; a preempted processor
        // command must not leave the new state without its own resets
        if (wd_req && !st_reg.bk_s2) begin
            st_next.cnt   = STATE_SLOW_CYCLES;
            st_next.cpu_n = 1'b0;
            st_next.per_n = wd_cpu_only;
            if (!wd_cpu_only) begin
                st_next.line_cnt  = line_load;
                st_next.own_drive = 1'b1;
            end
        end

        st_next.line_oe = (st_next.line_cnt != '0);
        // Interrupt only when the pin is not used as a reset
        st_next.irq = st_next.fall_seen & ~st_next.line_en & st_next.irq_en;
    end

    // State register; general reset leaves cause at general
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg           <= '0;
            st_reg.slow_s1   <= 1'b0;
            st_reg.pin_s1    <= 1'b1;
            st_reg.pin_s2    <= 1'b1;
            st_reg.pin_d     <= 1'b1;
            st_reg.state     <= ST_IDLE;
            st_reg.cause     <= CAUSE_GENERAL;
            st_reg.line_en   <= EN_RESET;
            st_reg.irq_en    <= IRQ_EN_RESET;
            st_reg.line_len  <= LEN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops, except line data, which is tied low
    assign prdata         = st_reg.rdata;
    assign pready         = st_reg.ready;
    assign pslverr        = st_reg.slverr;
    assign cpu_reset_n    = st_reg.cpu_n;
    assign periph_reset_n = st_reg.per_n;
    assign line_pin_out   = 1'b0;
    assign line_pin_oe    = st_reg.line_oe;
    assign reset_irq      = st_reg.irq;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_good_cmd;
        wr_cmd && st_reg.state == ST_IDLE && !st_reg.busy && !st_reg.bk_s2 && !wd_req;
    endsequence

    sequence s_bad_key;
        acc_done && pwrite && paddr == OFS_RESET_COMMAND && !key_ok;
    endsequence

    a_cmd_cpu_now: assert property (
        s_good_cmd ##0 pwdata[CMD_CPU_BIT] |=> !cpu_reset_n && st_reg.busy)
        else $error("processor command did not assert reset at once");

    a_cmd_line_pulse: assert property (
        s_good_cmd ##0 pwdata[CMD_LINE_BIT] |=> line_pin_oe [*2])
        else $error("line command did not drive the line");

    a_key_drop: assert property (
        s_bad_key ##0 st_reg.state == ST_IDLE && !st_reg.busy |=> !st_reg.busy)
        else $error("unkeyed command write took effect");

    a_busy_end: assert property (
        $fell(st_reg.busy) |-> $past(slow_tick) || $past(wd_req) || $past(st_reg.bk_s2))
        else $error("busy cleared away from a slow edge");

    a_wd_off_idle: assert property (
        wd_fault && !wd_reset_enable && st_reg.state == ST_IDLE && !st_reg.bk_s2
        && !wr_cmd && !st_reg.line_en |=> st_reg.state == ST_IDLE)
        else $error("disabled watchdog fault started a reset");

    a_cause_keep: assert property (
        rd_status && st_reg.state == ST_IDLE && !st_reg.bk_s2 |=> $stable(st_reg.cause))
        else $error("status read changed the reset cause");

    a_fall_sets: assert property (
        pin_fall |=> st_reg.fall_seen)
        else $error("pin fall did not set the flag");

    a_irq_gate: assert property (
        reset_irq |-> st_reg.fall_seen && !st_reg.line_en && st_reg.irq_en)
        else $error("interrupt raised without its conditions");

    a_wd_cpu_only: assert property (
        st_reg.state == ST_WDOG && wd_cpu_only && !st_reg.cpu_n |-> periph_reset_n)
        else $error("processor-only watchdog reset hit peripherals");

    a_own_pulse: assert property (
        line_pin_oe && st_reg.state == ST_IDLE |=> st_reg.state != ST_USER)
        else $error("own line pulse started a user reset");

    a_wd_cpu_low: assert property (
        st_reg.state == ST_WDOG |-> !cpu_reset_n)
        else $error("watchdog state without processor reset");

endmodule
`default_nettype wire

// ==== reset_state_pkg.sv ====
package reset_state_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_RESET_COMMAND = 8'h00;
    localparam logic [7:0] OFS_RESET_STATUS  = 8'h04;
    localparam logic [7:0] OFS_RESET_MODE    = 8'h08;

    // Write key, bits 31:24 of command and mode
    localparam logic [7:0] WRITE_KEY   = 8'hA5;
    localparam int         KEY_LSB     = 24;

    // Command bit positions
    localparam int CMD_CPU_BIT    = 0;
    localparam int CMD_PERIPH_BIT = 2;
    localparam int CMD_LINE_BIT   = 3;

    // Status field positions
    localparam int STS_FALL_BIT   = 0;
    localparam int STS_CAUSE_LSB  = 8;
    localparam int STS_LEVEL_BIT  = 16;
    localparam int STS_BUSY_BIT   = 17;

    // Mode field positions
    localparam int MODE_EN_BIT    = 0;
    localparam int MODE_IRQ_BIT   = 4;
    localparam int MODE_LEN_LSB   = 8;

    // Mode register reset values
    localparam logic [3:0] LEN_RESET    = 4'h0;
    localparam logic       EN_RESET     = 1'b0;
    localparam logic       IRQ_EN_RESET = 1'b0;

    // Last reset cause codes
    localparam logic [2:0] CAUSE_GENERAL  = 3'h0;
    localparam logic [2:0] CAUSE_BACKUP   = 3'h1;
    localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
    localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
    localparam logic [2:0] CAUSE_USER     = 3'h4;

    // Slow clock cycle counts
    localparam logic [1:0] STATE_SLOW_CYCLES   = 2'h3;
    localparam logic [1:0] STARTUP_SLOW_CYCLES = 2'h3;

    // Line pulse counter width, enough for 2^16 cycles
    localparam int LINE_CNT_W = 17;

    // Reset state machine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SOFT,
        ST_WDOG,
        ST_USER,
        ST_STARTUP,
        ST_BACKUP
    } rst_state_t;

endpackage

// ==== line_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// Other board devices on the open-drain reset line, pulled up
module line_partner (
    // Device side of the line
    input  wire logic line_pin_out,
    input  wire logic line_pin_oe,
    // A board device pulling the line low
    input  wire logic hold_low,
    // Wired level seen by all parties
    output logic      line_level
);
    // Any driver low wins; released line floats up to the pull-up
    // A board device may keep it low past the device's own pulse
    assign line_level = !((line_pin_oe && !line_pin_out) || hold_low);
endmodule
`default_nettype wire

// ==== reset_state_manager_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module reset_state_manager_tb;
    import reset_state_pkg::*;
    // Bus side
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    // Pins, watchdog and reset outputs
    logic        slow_clock, line_level, backup_req, hold_low, saw;
    logic        wd_fault, wd_cpu_only, wd_reset_enable, reset_irq;
    logic        cpu_reset_n, periph_reset_n, line_pin_out, line_pin_oe;
    // Expected read data, bits compared, expected error
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } note_t;
    note_t       notes[$];
    note_t       nt;
    int          num_errors, total_checks, cycles, slow_rises, r0;
    localparam int CPU = 0;
    localparam int PER = 1;
    localparam int OE  = 2;
    localparam logic [31:0] STM = 32'h00020700; // Busy and cause

    reset_state_manager u_reset_state_manager (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_clock(slow_clock), .line_pin_in(line_level), .backup_req(backup_req),
        .wd_fault(wd_fault), .wd_cpu_only(wd_cpu_only), .wd_reset_enable(wd_reset_enable),
        .cpu_reset_n(cpu_reset_n), .periph_reset_n(periph_reset_n),
        .line_pin_out(line_pin_out), .line_pin_oe(line_pin_oe), .reset_irq(reset_irq));
    line_partner u_line_partner (.line_pin_out(line_pin_out), .line_pin_oe(line_pin_oe),
        .hold_low(hold_low), .line_level(line_level));

    // Clocks; slow clock lasts ten bus periods, its edges on falling bus clock edges
    always #2 pclk = ~pclk;
    always #20 slow_clock = ~slow_clock;
    always @(posedge slow_clock) slow_rises++;

    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            total_checks++;
            if ((prdata & nt.mask) !== (nt.data & nt.mask) || pslverr !== nt.err) begin
                num_errors++;
                $display("unexpected at %0t: bus answer %h", $time, prdata);
            end
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // One transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        notes.push_back('{d, m, e});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait as long as the slave needs; the hang guard ends a stuck run
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask

    function automatic logic pick(input int s);
        case (s)
            CPU:     return cpu_reset_n;
            PER:     return periph_reset_n;
            default: return line_pin_oe;
        endcase
    endfunction

    // Bounded wait for an output level
    task automatic wait_lvl(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v && n < 800) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 800, "output level never came");
    endtask

    // Watch that neither processor nor peripheral reset drops for a while
    task automatic quiet(input int n);
        saw = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (cpu_reset_n !== 1'b1 || periph_reset_n !== 1'b1) saw = 1'b1;
        end
    endtask

    task automatic wd_pulse();
        @(posedge pclk);
        wd_fault <= 1'b1;
        @(posedge pclk);
        wd_fault <= 1'b0;
    endtask

    initial begin
        {pclk, slow_clock, presetn, psel, penable, pwrite, backup_req, hold_low} = 8'h00;
        {wd_fault, wd_cpu_only, wd_reset_enable} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(46911));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_RESET_STATUS, 32'h00010000, 32'hFFFFFFFF);
        rd(OFS_RESET_MODE, 32'h0, 32'hFFFFFFFF);
        // Wrong key never lands, reserved bits never stick
        rnd = $urandom;
        if (rnd[31:24] == WRITE_KEY) rnd[31:24] = 8'h5A;
        wr(OFS_RESET_MODE, {rnd[31:24], 24'h000F11});
        rd(OFS_RESET_MODE, 32'h0, 32'hFFFFFFFF);
        rnd = $urandom;
        wr(OFS_RESET_MODE, {WRITE_KEY, rnd[23:0]});
        rd(OFS_RESET_MODE, rnd & 32'h00000F11, 32'hFFFFFFFF);
        apb(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1'b1);
        // Peripheral command alone; a second command while busy is dropped
        wr(OFS_RESET_MODE, 32'hA5000100);
        wr(OFS_RESET_COMMAND, 32'hA5000004);
        r0 = slow_rises;
        @(posedge pclk);
        chk(periph_reset_n === 1'b0 && cpu_reset_n === 1'b1, "periph cmd");
        rd(OFS_RESET_STATUS, 32'h00020000, STM);
        wr(OFS_RESET_COMMAND, 32'hA5000001);
        @(posedge pclk);
        chk(cpu_reset_n === 1'b1, "cmd taken while busy");
        wait_lvl(PER, 1'b1);
        // A slow rise just before the write ticks after it, so two or three rises
        chk(slow_rises - r0 >= 2 && slow_rises - r0 <= 3, "sw state length");
        rd(OFS_RESET_STATUS, 32'h0, STM);
        // Processor and line together, user reset enabled
        wr(OFS_RESET_MODE, 32'hA5000101);
        wr(OFS_RESET_COMMAND, 32'hA5000009);
        r0 = slow_rises;
        @(posedge pclk);
        chk(cpu_reset_n === 1'b0 && line_pin_oe === 1'b1, "cpu+line cmd");
        chk(periph_reset_n === 1'b1, "periph hit");
        wait_lvl(OE, 1'b0);
        chk(slow_rises - r0 >= 3 && slow_rises - r0 <= 4, "line pulse length");
        wait_lvl(CPU, 1'b1);
        quiet(60);
        chk(!saw, "own pulse caused reset");
        rd(OFS_RESET_STATUS, 32'h00000300, STM);
        // Watchdog with reset disabled
        wd_pulse();
        quiet(60);
        chk(!saw, "disabled watchdog reset");
        // Watchdog, processor only; command refused meanwhile
        wd_reset_enable <= 1'b1;
        wd_cpu_only     <= 1'b1;
        wd_pulse();
        wait_lvl(CPU, 1'b0);
        chk(periph_reset_n === 1'b1 && line_pin_oe === 1'b0, "cpu-only wd");
        wr(OFS_RESET_COMMAND, 32'hA5000004);
        @(posedge pclk);
        chk(periph_reset_n === 1'b1, "cmd during wd");
        wait_lvl(CPU, 1'b1);
        rd(OFS_RESET_STATUS, 32'h00000200, STM);
        // Full watchdog preempts a processor command: cause ends as watchdog
        wd_cpu_only <= 1'b0;
        wr(OFS_RESET_COMMAND, 32'hA5000005);
        wd_pulse();
        wait_lvl(CPU, 1'b0);
        chk(periph_reset_n === 1'b0, "full wd periph");
        wait_lvl(OE, 1'b1);
        wait_lvl(CPU, 1'b1);
        wait_lvl(OE, 1'b0);
        repeat (40) @(posedge pclk);
        rd(OFS_RESET_STATUS, 32'h00000201, STM | 32'h1);
        // Pin fall raises the interrupt, status read clears it
        wr(OFS_RESET_MODE, 32'hA5000110);
        @(posedge pclk);
        chk(reset_irq === 1'b0, "irq without fall");
        hold_low <= 1'b1;
        repeat (10) @(posedge pclk);
        hold_low <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(reset_irq === 1'b1 && cpu_reset_n === 1'b1, "irq from fall");
        rd(OFS_RESET_STATUS, 32'h00000001, 32'h00000001);
        @(posedge pclk);
        chk(reset_irq === 1'b0, "irq kept after read");
        rd(OFS_RESET_STATUS, 32'h0, 32'h00000001);
        // User reset held low by a board device
        wr(OFS_RESET_MODE, 32'hA5000101);
        @(posedge pclk);
        hold_low <= 1'b1;
        wait_lvl(CPU, 1'b0);
        rd(OFS_RESET_STATUS, 32'h0, 32'h00010000);
        repeat (100) @(posedge pclk);
        chk(cpu_reset_n === 1'b0 && periph_reset_n === 1'b0, "released early");
        hold_low <= 1'b0;
        wait_lvl(CPU, 1'b1);
        rd(OFS_RESET_STATUS, 32'h00000400, STM);
        // Backup request outranks the rest; a watchdog fault meanwhile is ignored
        backup_req <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(cpu_reset_n === 1'b0 && periph_reset_n === 1'b0, "backup reset");
        wd_pulse();
        repeat (10) @(posedge pclk);
        backup_req <= 1'b0;
        wait_lvl(CPU, 1'b1);
        repeat (20) @(posedge pclk);
        rd(OFS_RESET_STATUS, 32'h00000100, 32'h00000700);
        // General reset in mid-run brings everything back to its reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_RESET_STATUS, 32'h00010000, 32'hFFFFFFFF);
        tally_and_finish();
    end
endmodule
`default_nettype wire
